// >>> timer_capture_pwm_unit.sv
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "timer_unit_consts.svh"
// How it works
// [RQ1] Timer 0 counts when enabled, divisor 2^n.
// [RQ2] Timer 0 interrupt only when enabled.
// [RQ3] Timer 0 overflow flag sticks until cleared.
// [RQ4] General prescaler divides by 2^code, upper zero.
// [RQ5] Mode bit: PWM/timer or capture/compare.
// [RQ6] Output enable drives pin; software sets direction.
// [RQ7] External clock counts on selected edge.
// [RQ8] Capture 1 pin used only when enabled.
// [RQ9] Capture 1 event optionally clears counter.
// [RQ10] Disabled timer stops and gates its clock.
// [RQ11] Writing force-high sets output, reads zero.
// [RQ12] Writing force-low clears output, reads zero.
// [RQ13] Link takes capture 2 from capture 1.
// [RQ14] Capture 2 edge: fall, rise, either.
// [RQ15] Capture 1 edge: fall, rise, either.
// [RQ16] Clear bit resets its timer, reads zero.
// [RQ17] Per-timer top interrupt enable gates requests.
// [RQ18] General overflow flag sticks until cleared.
// [RQ19] Event 2 flag: compare 2 or capture 2.
// [RQ20] Compare 1 flag sticks until cleared.
// [RQ21] Capture 1 flag sticks until cleared.
// [RQ22] Each flag interrupts only with its enable.
// [RQ23] Counter steps per tick, wraps to zero.
module timer_capture_pwm_unit #(
  parameter int CNT_W = 16,
  parameter int T0_W = 8
) (
  input wire logic CLK_SYS, // System clock, 10 MHz.
  input wire logic RST_B, // Asynchronous reset, active low.
  input wire logic [4:0] ADDR, // Register address.
  input wire logic [15:0] WR_DATA, // Write data.
  input wire logic WR_STB, // Write strobe.
  input wire logic RD_STB, // Read strobe.
  output logic [15:0] RD_DATA, // Read data, one cycle after the strobe.
  output logic T0_IRQ, // Timer 0 interrupt request.
  output logic [1:0] TMR_IRQ, // General timer interrupt requests.
  input wire logic [1:0] EXT_CLK_PIN, // External timer clocks.
  input wire logic [1:0] CAP1_PIN, // Capture 1 pins.
  input wire logic [1:0] CAP2_PIN, // Capture 2 pins.
  output logic [1:0] OUT_PIN, // Timer output pin levels.
  output logic [1:0] OUT_PIN_OE_B // Output enables, low while driving.
);

  ////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // True when the prescaler reaches the last count of its division.
  function automatic logic tick_due(input logic [14:0] pre, input logic [3:0] sel);
    logic [14:0] mask;
    mask = 15'((16'h1 << sel) - 16'h1);
    return (pre & mask) == mask;
  endfunction

  // Edge detect by selection code: falling, rising or either edge.
  function automatic logic edge_hit(input logic now, input logic was,
                                    input logic [1:0] sel);
    logic hit;
    case (sel)
      `EDGE_FALL: hit = was & ~now;
      `EDGE_RISE: hit = ~was & now;
      default: hit = was ^ now;
    endcase
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State.

  logic t0_run_reg, t0_run_next;
  logic [3:0] t0_ps_reg, t0_ps_next;
  logic t0_ie_reg, t0_ie_next;
  logic t0_flag_reg, t0_flag_next;
  logic [7:0] t0_pre_reg, t0_pre_next;
  logic [T0_W-1:0] t0_cnt_reg, t0_cnt_next;
  logic t0_irq_reg, t0_irq_next;
  logic [1:0] tie_reg, tie_next;
  logic [3:0] ien_reg [2];
  logic [3:0] ien_next [2];
  logic [3:0] flag_reg [2];
  logic [3:0] flag_next [2];
  logic [3:0] ps_reg [2];
  logic [3:0] ps_next [2];
  timer_unit_pkg::gen_ctrl_type ctrl_reg [2];
  timer_unit_pkg::gen_ctrl_type ctrl_next [2];
  timer_unit_pkg::cap_out_type capo_reg [2];
  timer_unit_pkg::cap_out_type capo_next [2];
  logic [14:0] pre_reg [2];
  logic [14:0] pre_next [2];
  logic [CNT_W-1:0] cnt_reg [2];
  logic [CNT_W-1:0] cnt_next [2];
  logic [CNT_W-1:0] cmp1_reg [2];
  logic [CNT_W-1:0] cmp1_next [2];
  logic [CNT_W-1:0] cmp2_reg [2];
  logic [CNT_W-1:0] cmp2_next [2];
  logic [CNT_W-1:0] cap_reg [2];
  logic [CNT_W-1:0] cap_next [2];
  logic [1:0] out_reg, out_next;
  logic [1:0] oe_b_reg, oe_b_next;
  logic [1:0] irq_reg, irq_next;
  logic [15:0] rd_reg, rd_next;
  timer_unit_pkg::pin_set_type sync1_reg [2];
  timer_unit_pkg::pin_set_type sync2_reg [2];
  timer_unit_pkg::pin_set_type prev_reg [2];

  // Per-cycle helpers.
  logic t0_step;
  logic [3:0] t0_sel;
  logic wr_t0, wr_pair;
  logic [7:0] wd8;
  logic [1:0] bank_hit, src_ev, step, c1_ev, c2_ev, m1_ev, ov_ev, clr_cmd;
  logic [CNT_W-1:0] cnt_inc [2];

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two stages plus one stage of history for edges.

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < 2; i++) begin
        sync1_reg[i] <= '0;
        sync2_reg[i] <= '0;
        prev_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        sync1_reg[i] <= {EXT_CLK_PIN[i], CAP1_PIN[i], CAP2_PIN[i]};
        sync2_reg[i] <= sync1_reg[i];
        prev_reg[i] <= sync2_reg[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic for registers, counters and outputs.

  always_comb begin
    t0_run_next = t0_run_reg;
    t0_ps_next = t0_ps_reg;
    t0_ie_next = t0_ie_reg;
    t0_flag_next = t0_flag_reg;
    t0_pre_next = t0_pre_reg;
    t0_cnt_next = t0_cnt_reg;
    tie_next = tie_reg;
    out_next = out_reg;
    oe_b_next = oe_b_reg;
    irq_next = irq_reg;
    rd_next = 16'h0000;
    wd8 = WR_DATA[7:0];
    wr_t0 = WR_STB && ADDR == `ADR_T0_CFG;
    wr_pair = WR_STB && ADDR == `ADR_PAIR_CMD;
    // Timer 0: reserved prescale codes act as the largest divisor.
    t0_sel = (t0_ps_reg > `T0_PS_MAX) ? `T0_PS_MAX : t0_ps_reg;
    t0_step = t0_run_reg && tick_due({7'h00, t0_pre_reg}, t0_sel); // RQ1
    if (t0_run_reg) begin
      t0_pre_next = t0_pre_reg + 8'h01; // RQ1
    end else begin
      t0_pre_next = 8'h00;
    end
    if (t0_step) begin
      t0_cnt_next = t0_cnt_reg + T0_W'(1);
    end
    if (wr_t0) begin
      t0_run_next = wd8[`T0_RUN_BIT];
      t0_ps_next = wd8[`T0_PS_HI:`T0_PS_LO];
      t0_ie_next = wd8[`T0_IE_BIT];
      t0_flag_next = t0_flag_reg & wd8[`T0_FLAG_BIT];
    end
    // The overflow sets the flag even in the cycle that software clears it.
    if (t0_step && t0_cnt_reg == '1) begin
      t0_flag_next = 1'b1; // RQ3
    end
    t0_irq_next = t0_flag_reg & t0_ie_reg; // RQ2
    if (wr_pair) begin
      tie_next = wd8[`PAIR_IE_LO +: 2];
    end
    clr_cmd = wr_pair ? wd8[`PAIR_CLR_LO +: 2] : 2'h0; // RQ16
    for (int i = 0; i < 2; i++) begin
      ien_next[i] = ien_reg[i];
      flag_next[i] = flag_reg[i];
      ps_next[i] = ps_reg[i];
      ctrl_next[i] = ctrl_reg[i];
      capo_next[i] = capo_reg[i];
      pre_next[i] = pre_reg[i];
      cnt_next[i] = cnt_reg[i];
      cmp1_next[i] = cmp1_reg[i];
      cmp2_next[i] = cmp2_reg[i];
      cap_next[i] = cap_reg[i];
      bank_hit[i] = ADDR[4:3] == ((i == 0) ? `BANK_A : `BANK_B);
      // Clock source: system clock, or the chosen edge of the external pin.
      src_ev[i] = ctrl_reg[i].ext_clk_en ?
        edge_hit(sync2_reg[i].ext_clk, prev_reg[i].ext_clk,
                 {1'b0, ~ctrl_reg[i].ext_edge}) : 1'b1; // RQ7
      step[i] = ctrl_reg[i].run && src_ev[i] &&
        tick_due(pre_reg[i], ps_reg[i]); // RQ4 RQ10
      cnt_inc[i] = cnt_reg[i] + CNT_W'(1); // RQ23
      // Capture events exist only in capture/compare mode.
      c1_ev[i] = ctrl_reg[i].run && ctrl_reg[i].mode && ctrl_reg[i].cap1_in_en &&
        edge_hit(sync2_reg[i].cap1, prev_reg[i].cap1,
                 capo_reg[i].cap1_edge); // RQ5 RQ8 RQ15
      if (capo_reg[i].link) begin
        c2_ev[i] = edge_hit(sync2_reg[i].cap1, prev_reg[i].cap1,
                            capo_reg[i].cap2_edge); // RQ13 RQ14
      end else begin
        c2_ev[i] = edge_hit(sync2_reg[i].cap2, prev_reg[i].cap2,
                            capo_reg[i].cap2_edge); // RQ14
      end
      c2_ev[i] = c2_ev[i] && ctrl_reg[i].run && ctrl_reg[i].mode &&
        ctrl_reg[i].cap2_in_en;
      m1_ev[i] = step[i] && cnt_inc[i] == cmp1_reg[i];
      ov_ev[i] = step[i] && cnt_reg[i] == '1; // RQ23
      // A stopped timer holds its count except on a clear command; its prescaler rests at zero.
      if (!ctrl_reg[i].run) begin
        pre_next[i] = 15'h0000; // RQ10
      end else if (src_ev[i]) begin
        pre_next[i] = pre_reg[i] + 15'h0001;
      end
      if (clr_cmd[i]) begin
        cnt_next[i] = '0; // RQ16
        pre_next[i] = 15'h0000;
      end else if (c1_ev[i] && ctrl_reg[i].cap1_clr) begin
        cnt_next[i] = '0; // RQ9
      end else if (step[i]) begin
        cnt_next[i] = cnt_inc[i]; // RQ23
      end
      if (c1_ev[i]) begin
        cap_next[i] = cnt_reg[i];
      end
      // PWM: set at wrap, clear at compare 1; compare mode toggles.
      if (!ctrl_reg[i].mode) begin
        if (ov_ev[i]) begin
          out_next[i] = 1'b1; // RQ5
        end
        if (m1_ev[i]) begin
          out_next[i] = 1'b0;
        end
      end else if (m1_ev[i]) begin
        out_next[i] = ~out_reg[i]; // RQ5
      end
      if (WR_STB && bank_hit[i]) begin
        case (ADDR[2:0])
          `SLOT_IRQ: begin
            ien_next[i] = wd8[`IEN_LO +: 4];
            flag_next[i] = flag_reg[i] & wd8[3:0];
          end
          `SLOT_PS: ps_next[i] = wd8[3:0];
          `SLOT_CTRL: ctrl_next[i] = timer_unit_pkg::gen_ctrl_type'(wd8);
          `SLOT_CAPO: begin
            capo_next[i] = timer_unit_pkg::cap_out_type'({3'h0, wd8[4:0]});
            if (wd8[`FORCE_HI_BIT]) begin
              out_next[i] = 1'b1; // RQ11
            end
            if (wd8[`FORCE_LO_BIT]) begin
              out_next[i] = 1'b0; // RQ12
            end
          end
          `SLOT_CMP1: cmp1_next[i] = CNT_W'(WR_DATA);
          `SLOT_CMP2: cmp2_next[i] = CNT_W'(WR_DATA);
          default: ;
        endcase
      end
      // Events set flags after the clear, so a set in the same cycle wins.
      flag_next[i][`EV_OVF] = flag_next[i][`EV_OVF] | ov_ev[i]; // RQ18
      flag_next[i][`EV_EV2] = flag_next[i][`EV_EV2] | (ctrl_reg[i].mode ?
        c2_ev[i] : (step[i] && cnt_inc[i] == cmp2_reg[i])); // RQ19
      flag_next[i][`EV_CAP1] = flag_next[i][`EV_CAP1] | c1_ev[i]; // RQ21
      flag_next[i][`EV_CMP1] = flag_next[i][`EV_CMP1] | m1_ev[i]; // RQ20
      oe_b_next[i] = ~ctrl_reg[i].out_en; // RQ6
      irq_next[i] = tie_reg[i] && |(flag_reg[i] & ien_reg[i]); // RQ17 RQ22
    end
    // Read data; force bits, clear bits and reserved bits read as zero.
    if (RD_STB) begin
      case (ADDR)
        `ADR_T0_CFG: rd_next = {8'h00, t0_run_reg, t0_ps_reg, 1'b0,
                                t0_ie_reg, t0_flag_reg};
        `ADR_T0_CNT: rd_next = 16'(t0_cnt_reg);
        `ADR_PAIR_CMD: rd_next = {10'h000, tie_reg, 4'h0};
        default: begin
          for (int i = 0; i < 2; i++) begin
            if (bank_hit[i]) begin
              case (ADDR[2:0])
                `SLOT_IRQ: rd_next = {8'h00, ien_reg[i], flag_reg[i]};
                `SLOT_PS: rd_next = {12'h000, ps_reg[i]}; // RQ4
                `SLOT_CTRL: rd_next = {8'h00, ctrl_reg[i]};
                `SLOT_CAPO: rd_next = {8'h00, capo_reg[i]}; // RQ11 RQ12
                `SLOT_CNT: rd_next = 16'(cnt_reg[i]);
                `SLOT_CMP1: rd_next = 16'(cmp1_reg[i]);
                `SLOT_CMP2: rd_next = 16'(cmp2_reg[i]);
                default: rd_next = 16'(cap_reg[i]);
              endcase
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers.

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      t0_run_reg <= 1'b0;
      t0_ps_reg <= 4'h0;
      t0_ie_reg <= 1'b0;
      t0_flag_reg <= 1'b0;
      t0_pre_reg <= 8'h00;
      t0_cnt_reg <= '0;
      t0_irq_reg <= 1'b0;
      tie_reg <= 2'h0;
      out_reg <= 2'h0;
      oe_b_reg <= 2'h3;
      irq_reg <= 2'h0;
      rd_reg <= 16'h0000;
      for (int i = 0; i < 2; i++) begin
        ien_reg[i] <= 4'h0;
        flag_reg[i] <= 4'h0;
        ps_reg[i] <= 4'h0;
        ctrl_reg[i] <= `CFG_RST;
        capo_reg[i] <= `CFG_RST;
        pre_reg[i] <= 15'h0000;
        cnt_reg[i] <= '0;
        cmp1_reg[i] <= '0;
        cmp2_reg[i] <= '0;
        cap_reg[i] <= '0;
      end
    end else begin
      t0_run_reg <= t0_run_next;
      t0_ps_reg <= t0_ps_next;
      t0_ie_reg <= t0_ie_next;
      t0_flag_reg <= t0_flag_next;
      t0_pre_reg <= t0_pre_next;
      t0_cnt_reg <= t0_cnt_next;
      t0_irq_reg <= t0_irq_next;
      tie_reg <= tie_next;
      out_reg <= out_next;
      oe_b_reg <= oe_b_next;
      irq_reg <= irq_next;
      rd_reg <= rd_next;
      for (int i = 0; i < 2; i++) begin
        ien_reg[i] <= ien_next[i];
        flag_reg[i] <= flag_next[i];
        ps_reg[i] <= ps_next[i];
        ctrl_reg[i] <= ctrl_next[i];
        capo_reg[i] <= capo_next[i];
        pre_reg[i] <= pre_next[i];
        cnt_reg[i] <= cnt_next[i];
        cmp1_reg[i] <= cmp1_next[i];
        cmp2_reg[i] <= cmp2_next[i];
        cap_reg[i] <= cap_next[i];
      end
    end
  end

  // Outputs come straight from flip-flops.
  assign RD_DATA = rd_reg;
  assign T0_IRQ = t0_irq_reg;
  assign TMR_IRQ = irq_reg;
  assign OUT_PIN = out_reg;
  assign OUT_PIN_OE_B = oe_b_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);

  // Timer 0 is about to wrap.
  sequence seq_t0_wrap;
    t0_step && t0_cnt_reg == '1;
  endsequence

  a_t0_hold_count: assert property (!t0_run_reg |=> $stable(t0_cnt_reg)) // RQ1
    else $error("Timer 0 moved while disabled.");
  a_t0_irq_gate: assert property ((!t0_ie_reg) [*2] |-> !T0_IRQ) // RQ2
    else $error("Timer 0 interrupt while disabled.");
  a_t0_wrap_flag: assert property (seq_t0_wrap |=> t0_flag_reg && t0_cnt_reg == '0) // RQ3
    else $error("Timer 0 wrap did not set its flag.");
  a_t0_flag_sticky: assert property (t0_flag_reg && !wr_t0 |=> t0_flag_reg) // RQ3
    else $error("Timer 0 flag dropped by itself.");

  for (genvar g = 0; g < 2; g++) begin : g_chk
    a_gen_stopped: assert property (!ctrl_reg[g].run && !clr_cmd[g]
        |=> $stable(cnt_reg[g])) // RQ10
      else $error("General timer moved while disabled.");
    a_gen_clear: assert property (clr_cmd[g] |=> cnt_reg[g] == '0) // RQ16
      else $error("Clear command did not clear the timer.");
    a_force_high: assert property (WR_STB && bank_hit[g] && ADDR[2:0] == `SLOT_CAPO
        && wd8[`FORCE_HI_BIT] && !wd8[`FORCE_LO_BIT] |=> OUT_PIN[g]) // RQ11
      else $error("Force high did not raise the output.");
    a_force_low: assert property (WR_STB && bank_hit[g] && ADDR[2:0] == `SLOT_CAPO
        && wd8[`FORCE_LO_BIT] |=> !OUT_PIN[g]) // RQ12
      else $error("Force low did not lower the output.");
    a_cap1_clear: assert property (c1_ev[g] && ctrl_reg[g].cap1_clr && !clr_cmd[g]
        |=> cnt_reg[g] == '0) // RQ9
      else $error("Capture 1 did not clear the counter.");
    a_ovf_flag: assert property (ov_ev[g] |=> flag_reg[g][`EV_OVF]
        ##1 (irq_reg[g] || !$past(tie_reg[g] && ien_reg[g][`EV_OVF]))) // RQ18
      else $error("Overflow flag or its request missing.");
    a_irq_gate: assert property (!tie_reg[g] |=> !TMR_IRQ[g]) // RQ17
      else $error("Timer interrupt while its top enable is off.");
    a_pin_drive: assert property (ctrl_reg[g].out_en |=> !OUT_PIN_OE_B[g]) // RQ6
      else $error("Output enabled but pin not driven.");
  end

endmodule

// >>> timer_capture_pwm_unit_tb.sv
`timescale 1ns/1ps
`include "timer_unit_consts.svh"
module timer_capture_pwm_unit_tb;
  localparam int LIMIT = 80000;
  logic CLK_SYS = 1'b0;
  logic RST_B = 1'b0;
  logic [4:0] ADDR = 5'h00;
  logic [15:0] WR_DATA = 16'h0000;
  logic WR_STB = 1'b0;
  logic RD_STB = 1'b0;
  logic [15:0] RD_DATA;
  logic T0_IRQ;
  logic [1:0] TMR_IRQ, EXT_CLK_PIN, CAP1_PIN, CAP2_PIN, OUT_PIN, OUT_PIN_OE_B, pad;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  logic [15:0] d;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock of 100 ns period.
  always #50 CLK_SYS = ~CLK_SYS;

  timer_capture_pwm_unit u_dut (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .T0_IRQ(T0_IRQ),
    .TMR_IRQ(TMR_IRQ), .EXT_CLK_PIN(EXT_CLK_PIN), .CAP1_PIN(CAP1_PIN),
    .CAP2_PIN(CAP2_PIN), .OUT_PIN(OUT_PIN), .OUT_PIN_OE_B(OUT_PIN_OE_B)
  );

  timer_pins_model u_pins (
    .clk(CLK_SYS), .ext_clk(EXT_CLK_PIN), .cap1(CAP1_PIN), .cap2(CAP2_PIN),
    .out_lvl(OUT_PIN), .out_oe_b(OUT_PIN_OE_B), .pad(pad)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops the run.
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short after a cycle ceiling well above the planned run.
  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [4:0] adr, input logic [15:0] dat);
    @(posedge CLK_SYS);
    ADDR <= adr;
    WR_DATA <= dat;
    WR_STB <= 1'b1;
    @(posedge CLK_SYS);
    WR_STB <= 1'b0;
  endtask

  // One-cycle read strobe; data are taken in the cycle after it.
  task automatic rd(input logic [4:0] adr, output logic [15:0] dat);
    @(posedge CLK_SYS);
    ADDR <= adr;
    RD_STB <= 1'b1;
    @(posedge CLK_SYS);
    RD_STB <= 1'b0;
    #1;
    dat = RD_DATA;
  endtask

  task automatic rdchk(input string what, input logic [4:0] adr, input logic [15:0] exp);
    logic [15:0] v;
    rd(adr, v);
    chk(what, exp, v);
  endtask

  function automatic logic [4:0] ra(input logic [2:0] slot);
    return {`BANK_A, slot};
  endfunction

  // Advance of a counter over gap plus two cycles between the reads.
  task automatic delta(input logic [4:0] adr, input int gap, output logic [15:0] dd);
    logic [15:0] x;
    logic [15:0] y;
    rd(adr, x);
    repeat (gap) @(posedge CLK_SYS);
    rd(adr, y);
    dd = y - x;
  endtask

  // Clears the flags, moves one pin, then compares the capture flags.
  task automatic edge_chk(input int kind, input logic lvl, input logic [15:0] exp);
    logic [15:0] v;
    wr(ra(`SLOT_IRQ), 16'h0000);
    u_pins.drive(kind, 0, lvl);
    rd(ra(`SLOT_IRQ), v);
    chk("capture flags", exp, v & 16'h0006);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk("t0 config", `ADR_T0_CFG, 16'h0000);
    rdchk("control", ra(`SLOT_CTRL), 16'h0000);
    rdchk("unmapped", 5'h18, 16'h0000);
    chk("enable pins", 16'h0003, {14'h0000, OUT_PIN_OE_B});
  endtask

  task automatic t_timer0();
    wr(`ADR_T0_CFG, 16'h0090);
    delta(`ADR_T0_CNT, 38, d);
    chk("t0 step", 16'h000A, {8'h00, d[7:0]});
    wr(`ADR_T0_CFG, 16'h0010);
    delta(`ADR_T0_CNT, 38, d);
    chk("t0 hold", 16'h0000, {8'h00, d[7:0]});
    wr(`ADR_T0_CFG, 16'h0080);
    repeat (300) @(posedge CLK_SYS);
    rdchk("t0 flag", `ADR_T0_CFG, 16'h0081);
    chk("t0 masked", 16'h0000, {15'h0000, T0_IRQ});
    wr(`ADR_T0_CFG, 16'h0003);
    repeat (3) @(posedge CLK_SYS);
    chk("t0 request", 16'h0001, {15'h0000, T0_IRQ});
    rdchk("t0 sticky", `ADR_T0_CFG, 16'h0003);
    wr(`ADR_T0_CFG, 16'h0002);
    repeat (3) @(posedge CLK_SYS);
    chk("t0 cleared", 16'h0000, {15'h0000, T0_IRQ});
    rdchk("t0 cleared flag", `ADR_T0_CFG, 16'h0002);
  endtask

  task automatic t_prescale();
    wr(ra(`SLOT_PS), 16'h00FF);
    rdchk("prescale", ra(`SLOT_PS), 16'h000F);
    wr(ra(`SLOT_PS), 16'h0001);
    wr(ra(`SLOT_CTRL), 16'h0001);
    delta(ra(`SLOT_CNT), 18, d);
    chk("gen step", 16'h000A, d);
    wr(ra(`SLOT_CTRL), 16'h0000);
    delta(ra(`SLOT_CNT), 18, d);
    chk("gen hold", 16'h0000, d);
    wr(ra(`SLOT_PS), 16'h0000);
  endtask

  task automatic t_extclk();
    logic [15:0] x;
    for (int e = 0; e < 2; e++) begin
      wr(ra(`SLOT_CTRL), 16'h0021 | 16'(e * 4));
      rd(ra(`SLOT_CNT), x);
      u_pins.drive(0, 0, 1'b1);
      rdchk("rising step", ra(`SLOT_CNT), x + 16'(1 - e));
      u_pins.drive(0, 0, 1'b0);
      rdchk("falling step", ra(`SLOT_CNT), x + 16'h0001);
    end
    wr(ra(`SLOT_CTRL), 16'h0020);
    rd(ra(`SLOT_CNT), x);
    u_pins.drive(0, 0, 1'b1);
    u_pins.drive(0, 0, 1'b0);
    rdchk("gated clock", ra(`SLOT_CNT), x);
  endtask

  // Both timers in turn, so that both output pins are looked at.
  task automatic t_force();
    for (int b = 0; b < 2; b++) begin
      wr({2'(b + 1), `SLOT_CTRL}, 16'h0040);
      repeat (3) @(posedge CLK_SYS);
      chk("pin driven", 16'h0000, {15'h0000, OUT_PIN_OE_B[b]});
      wr({2'(b + 1), `SLOT_CAPO}, 16'h0040);
      wr({2'(b + 1), `SLOT_CAPO}, 16'h0000);
      repeat (3) @(posedge CLK_SYS);
      chk("forced high", 16'h0001, {15'h0000, pad[b]});
      rdchk("force bits", {2'(b + 1), `SLOT_CAPO}, 16'h0000);
      wr({2'(b + 1), `SLOT_CAPO}, 16'h0020);
      repeat (3) @(posedge CLK_SYS);
      chk("forced low", 16'h0000, {15'h0000, pad[b]});
      wr({2'(b + 1), `SLOT_CTRL}, 16'h0000);
      repeat (3) @(posedge CLK_SYS);
      chk("pin released", 16'h0001, {15'h0000, OUT_PIN_OE_B[b]});
    end
  endtask

  task automatic t_capture();
    wr(ra(`SLOT_CTRL), 16'h0099);
    for (int c = 0; c < 3; c++) begin
      wr(ra(`SLOT_CAPO), 16'(c * 5));
      edge_chk(1, 1'b1, (c != 0) ? 16'h0002 : 16'h0000);
      edge_chk(1, 1'b0, (c != 1) ? 16'h0002 : 16'h0000);
      edge_chk(2, 1'b1, (c != 0) ? 16'h0004 : 16'h0000);
      edge_chk(2, 1'b0, (c != 1) ? 16'h0004 : 16'h0000);
    end
    wr(ra(`SLOT_CAPO), 16'h0015);
    edge_chk(1, 1'b1, 16'h0006);
    edge_chk(1, 1'b0, 16'h0000);
    wr(ra(`SLOT_CTRL), 16'h0081);
    edge_chk(1, 1'b1, 16'h0000);
    edge_chk(1, 1'b0, 16'h0000);
    wr(ra(`SLOT_CTRL), 16'h0009);
    edge_chk(1, 1'b1, 16'h0000);
    u_pins.drive(1, 0, 1'b0);
  endtask

  task automatic t_clear();
    wr(ra(`SLOT_CAPO), 16'h0001);
    wr(ra(`SLOT_CTRL), 16'h008B);
    repeat (100) @(posedge CLK_SYS);
    u_pins.drive(1, 0, 1'b1);
    rd(ra(`SLOT_CNT), d);
    chk("capture clears", 16'h0001, {15'h0000, d < 16'h0010});
    u_pins.drive(1, 0, 1'b0);
    wr(ra(`SLOT_CTRL), 16'h0089);
    repeat (100) @(posedge CLK_SYS);
    u_pins.drive(1, 0, 1'b1);
    rd(ra(`SLOT_CNT), d);
    chk("capture keeps", 16'h0001, {15'h0000, d >= 16'h0064});
    u_pins.drive(1, 0, 1'b0);
    wr(`ADR_PAIR_CMD, 16'h0001);
    rd(ra(`SLOT_CNT), d);
    chk("command clear", 16'h0001, {15'h0000, d < 16'h0008});
  endtask

  task automatic t_compare();
    wr(ra(`SLOT_CMP1), 16'h0040);
    wr(ra(`SLOT_CMP2), 16'h0020);
    wr(ra(`SLOT_CTRL), 16'h0001);
    wr(`ADR_PAIR_CMD, 16'h0001);
    wr(ra(`SLOT_IRQ), 16'h0000);
    repeat (100) @(posedge CLK_SYS);
    rdchk("compare flags", ra(`SLOT_IRQ), 16'h0005);
    wr(ra(`SLOT_IRQ), 16'h0015);
    repeat (3) @(posedge CLK_SYS);
    chk("top enable off", 16'h0000, {14'h0000, TMR_IRQ});
    wr(`ADR_PAIR_CMD, 16'h0031);
    repeat (3) @(posedge CLK_SYS);
    chk("request", 16'h0001, {14'h0000, TMR_IRQ});
    rdchk("command", `ADR_PAIR_CMD, 16'h0030);
    wr(ra(`SLOT_IRQ), 16'h0025);
    repeat (3) @(posedge CLK_SYS);
    chk("other enable", 16'h0000, {14'h0000, TMR_IRQ});
    wr(`ADR_PAIR_CMD, 16'h0001);
    wr(ra(`SLOT_IRQ), 16'h0000);
    repeat (65600) @(posedge CLK_SYS);
    rd(ra(`SLOT_IRQ), d);
    chk("overflow flag", 16'h0008, d & 16'h0008);
    wr(ra(`SLOT_IRQ), 16'h0080);
    rd(ra(`SLOT_IRQ), d);
    chk("overflow cleared", 16'h0000, d & 16'h0008);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset for 20 cycles, then the scenarios in turn.
  initial begin
    repeat (20) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    @(posedge CLK_SYS);
    t_reset();
    t_timer0();
    t_prescale();
    t_extclk();
    t_force();
    t_capture();
    t_clear();
    t_compare();
    close_out();
  end
endmodule

// >>> timer_pins_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Far side of the timers: external clock, capture inputs and the output pad.
module timer_pins_model (
  input wire logic clk, // System clock, paces the pin changes.
  output logic [1:0] ext_clk, // External timer clocks.
  output logic [1:0] cap1, // Capture 1 inputs.
  output logic [1:0] cap2, // Capture 2 inputs.
  input wire logic [1:0] out_lvl, // Level the timer would drive.
  input wire logic [1:0] out_oe_b, // Output enables, low while driving.
  output logic [1:0] pad // Resolved pad level.
);
  // All input pins idle low until a scenario moves them.
  initial begin
    ext_clk = 2'h0;
    cap1 = 2'h0;
    cap2 = 2'h0;
  end
  // A released pad is pulled high on the board, so a stale level never shows.
  assign pad = (out_lvl & ~out_oe_b) | out_oe_b;
  // Moves one pin after an edge and holds it well past the two-cycle minimum.
  task automatic drive(input int kind, input int idx, input logic lvl);
    @(posedge clk);
    case (kind)
      0: ext_clk[idx] <= lvl;
      1: cap1[idx] <= lvl;
      default: cap2[idx] <= lvl;
    endcase
    repeat (8) @(posedge clk);
  endtask
endmodule

// >>> timer_unit_consts.svh
`ifndef TIMER_UNIT_CONSTS_SVH
`define TIMER_UNIT_CONSTS_SVH
// Register addresses and slots inside a general timer bank.
`define ADR_T0_CFG 5'h00
`define ADR_T0_CNT 5'h01
`define ADR_PAIR_CMD 5'h02
`define BANK_A 2'h1
`define BANK_B 2'h2
`define SLOT_IRQ 3'h0
`define SLOT_PS 3'h1
`define SLOT_CTRL 3'h2
`define SLOT_CAPO 3'h3
`define SLOT_CNT 3'h4
`define SLOT_CMP1 3'h5
`define SLOT_CMP2 3'h6
`define SLOT_CAP1 3'h7
// Field positions.
`define T0_RUN_BIT 7
`define T0_PS_HI 6
`define T0_PS_LO 3
`define T0_IE_BIT 1
`define T0_FLAG_BIT 0
`define T0_PS_MAX 4'h8
`define PAIR_IE_LO 4
`define PAIR_CLR_LO 0
`define IEN_LO 4
`define EV_OVF 3
`define EV_EV2 2
`define EV_CAP1 1
`define EV_CMP1 0
`define FORCE_HI_BIT 6
`define FORCE_LO_BIT 5
// Edge selection codes and reset value.
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define CFG_RST 8'h00
`endif

// >>> timer_unit_pkg.sv
package timer_unit_pkg;
  // Control byte of a general timer.
  typedef struct packed {
    logic mode;
    logic out_en;
    logic ext_clk_en;
    logic cap2_in_en;
    logic cap1_in_en;
    logic ext_edge;
    logic cap1_clr;
    logic run;
  } gen_ctrl_type;
  // Capture and output control byte, force bits are never stored.
  typedef struct packed {
    logic rsvd;
    logic force_high;
    logic force_low;
    logic link;
    logic [1:0] cap2_edge;
    logic [1:0] cap1_edge;
  } cap_out_type;
  // The three input pins of one general timer.
  typedef struct packed {
    logic ext_clk;
    logic cap1;
    logic cap2;
  } pin_set_type;
endpackage
